// ---- qdel_cfg.svh ----
`ifndef QDEL_CFG_SVH
`define QDEL_CFG_SVH

// =====================================================================
// sizes
`define QDEL_NUM_CH          8
`define QDEL_NUM_REGIONS     4
`define QDEL_REGION_W        2
`define QDEL_ENTRY_W         9
`define QDEL_WORD_W          3
`define QDEL_INT_W           32
`define QDEL_ADDR_W          8

// =====================================================================
// register byte offsets, one aligned word each
`define QDEL_OFS_EVENT_FLAGS  8'h00
`define QDEL_OFS_ENABLE       8'h04
`define QDEL_OFS_ENABLE_CLEAR 8'h08
`define QDEL_OFS_ENABLE_SET   8'h0c
`define QDEL_OFS_SEC_CLEAR    8'h10
`define QDEL_OFS_INT_EVALUATE_BIT     8'h14

// =====================================================================
// field positions and reset values
`define QDEL_EVALUATE_BIT_BIT         0
`define QDEL_EVALUATE_BIT_RSVD_BIT    1
`define QDEL_FLAGS_RST        8'h00
`define QDEL_ENABLE_RST       8'h00
`define QDEL_MISSED_RST       8'h00

`endif

// ---- qdel_pkg.sv ----
package qdel_pkg;

	// offer state of the submission port, one-hot
	typedef enum logic [1:0] {
		QDEL_IDLE  = 2'b01,
		QDEL_OFFER = 2'b10
	} qdel_offer_t;

	typedef logic [7:0] qdel_chmask_t;

endpackage

// ---- qdel_event_latch.sv ----
`timescale 1ns/10ps
`include "qdel_cfg.svh"

// =====================================================================
module qdel_event_latch
	import qdel_pkg::*;
(
	input  wire logic                                        clk,
	input  wire logic                                        srst,
	// register port
	input  wire logic                                        reg_wr,
	input  wire logic                                        reg_rd,
	input  wire logic                                        reg_global,
	input  wire logic [`QDEL_REGION_W-1:0]                   reg_region,
	input  wire logic [`QDEL_ADDR_W-1:0]                     reg_addr,
	input  wire logic [31:0]                                 reg_wdata,
	output logic      [31:0]                                 reg_rdata,
	output logic                                             reg_rvalid,
	// shadow region access masks, region k in slice k
	input  wire logic [`QDEL_NUM_REGIONS*`QDEL_NUM_CH-1:0]   quick_region_access_enable,
	input  wire logic [`QDEL_NUM_REGIONS*`QDEL_INT_W-1:0]    dma_region_access_enable,
	// completion interrupt state
	input  wire logic [`QDEL_INT_W-1:0]                      completion_interrupt_enable,
	input  wire logic [`QDEL_INT_W-1:0]                      completion_interrupt_pending,
	output logic                                             global_completion_pulse,
	output logic      [`QDEL_NUM_REGIONS-1:0]                region_completion_pulse,
	// channel to parameter_ram mapping, channel n in slice n
	input  wire logic [`QDEL_NUM_CH*`QDEL_ENTRY_W-1:0]       quick_channel_parameter_ram_mapping,
	input  wire logic [`QDEL_NUM_CH*`QDEL_WORD_W-1:0]        quick_channel_trigger_word,
	// parameter_ram write and link update observation
	input  wire logic                                        parameter_ram_wr_valid,
	input  wire logic [`QDEL_ENTRY_W-1:0]                    parameter_ram_wr_entry,
	input  wire logic [`QDEL_WORD_W-1:0]                     parameter_ram_wr_word,
	input  wire logic                                        link_upd_valid,
	input  wire logic [`QDEL_ENTRY_W-1:0]                    link_upd_entry,
	// transfer_request submission
	output logic                                             submit_valid,
	output logic      [2:0]                                  submit_channel,
	input  wire logic                                        submit_ready,
	// missed events
	output logic      [`QDEL_NUM_CH-1:0]                     quick_channel_missed_events,
	input  wire logic [`QDEL_NUM_CH-1:0]                     missed_clear,
	output logic      [`QDEL_NUM_CH-1:0]                     quick_secondary_event_clear
);

	// =================================================================
	// state
	qdel_chmask_t                  flags_ff;
	qdel_chmask_t                  enable_ff;
	qdel_chmask_t                  missed_ff;
	qdel_chmask_t                  sec_clr_ff;
	qdel_offer_t                   offer_ff;
	logic [2:0]                    offer_ch_ff;
	logic [31:0]                   rdata_ff;
	logic                          rvalid_ff;
	logic                          geval_ff;
	logic [`QDEL_NUM_REGIONS-1:0]  reval_ff;

	// =================================================================
	// decode
	qdel_chmask_t                  acc_mask;
	qdel_chmask_t                  wdata8;
	qdel_chmask_t                  trig_hit;
	qdel_chmask_t                  event_in;
	qdel_chmask_t                  hw_clear;
	qdel_chmask_t                  sw_clear;
	qdel_chmask_t                  en_set;
	qdel_chmask_t                  en_clr;
	qdel_chmask_t                  nxt_flags;
	qdel_chmask_t                  nxt_enable;
	logic                          wr_en_clr;
	logic                          wr_en_set;
	logic                          wr_sec_clr;
	logic                          wr_evaluate_bit;
	logic                          evaluate_bit_req;
	logic [`QDEL_INT_W-1:0]        live_int;
	logic [`QDEL_INT_W-1:0]        region_int_mask;
	logic [2:0]                    low_ch;
	logic [31:0]                   nxt_rdata;

	// only the low byte holds channel bits; the rest is reserved
	assign wdata8 = reg_wdata[`QDEL_NUM_CH-1:0];

	// shadow accesses only reach channels granted to the region
	always_comb begin
		if (reg_global) begin
			acc_mask = 8'hff;
		end else begin
			acc_mask = quick_region_access_enable[reg_region*`QDEL_NUM_CH +: `QDEL_NUM_CH];
		end
	end

	// register write strobes, address decode
	always_comb begin
		wr_en_clr  = 1'b0;
		wr_en_set  = 1'b0;
		wr_sec_clr = 1'b0;
		wr_evaluate_bit    = 1'b0;
		if (reg_wr && reg_addr == `QDEL_OFS_ENABLE_CLEAR) begin
			wr_en_clr = 1'b1;
		end else if (reg_wr && reg_addr == `QDEL_OFS_ENABLE_SET) begin
			wr_en_set = 1'b1;
		end else if (reg_wr && reg_addr == `QDEL_OFS_SEC_CLEAR) begin
			wr_sec_clr = 1'b1;
		end else if (reg_wr && reg_addr == `QDEL_OFS_INT_EVALUATE_BIT) begin
			wr_evaluate_bit = 1'b1;
		end
	end

	assign en_clr   = wr_en_clr ? (wdata8 & acc_mask) : 8'h00;
	assign en_set   = wr_en_set ? (wdata8 & acc_mask) : 8'h00;
	assign sw_clear = wr_sec_clr ? (wdata8 & acc_mask) : 8'h00;
	// bit 1 is ignored: software keeps it zero
	assign evaluate_bit_req = wr_evaluate_bit & reg_wdata[`QDEL_EVALUATE_BIT_BIT];

	// =================================================================
	// per-channel event detection
	// one matcher per channel, bit n of every mask is channel n
	genvar ch;
	generate
		for (ch = 0; ch < `QDEL_NUM_CH; ch++) begin : g_ch
			logic [`QDEL_ENTRY_W-1:0] map_entry;
			logic [`QDEL_WORD_W-1:0]  map_word;
			assign map_entry = quick_channel_parameter_ram_mapping[ch*`QDEL_ENTRY_W +: `QDEL_ENTRY_W];
			assign map_word  = quick_channel_trigger_word[ch*`QDEL_WORD_W +: `QDEL_WORD_W];
			// trigger word write or whole-entry link update
			assign trig_hit[ch] = (parameter_ram_wr_valid && parameter_ram_wr_entry == map_entry
				&& parameter_ram_wr_word == map_word)
				|| (link_upd_valid && link_upd_entry == map_entry);
		end
	endgenerate

	// disabled channels drop the event entirely
	assign event_in = trig_hit & enable_ff;

	// hardware clear only on accepted submission
	always_comb begin
		hw_clear = 8'h00;
		if (submit_valid && submit_ready) begin
			hw_clear[offer_ch_ff] = 1'b1;
		end
	end

	// set beats any concurrent clear
	assign nxt_flags = (flags_ff & ~(hw_clear | sw_clear)) | event_in;

	// =================================================================
	// event flags
	always_ff @(posedge clk) begin
		if (srst) begin
			flags_ff <= `QDEL_FLAGS_RST;
		end else begin
			flags_ff <= nxt_flags;
		end
	end

	// new event on an already set flag is lost
	// a miss in the same cycle as missed_clear survives
	always_ff @(posedge clk) begin
		if (srst) begin
			missed_ff <= `QDEL_MISSED_RST;
		end else begin
			missed_ff <= (missed_ff & ~missed_clear) | (event_in & flags_ff);
		end
	end

	// =================================================================
	// enables: no direct write path exists
	assign nxt_enable = (enable_ff & ~en_clr) | en_set;

	always_ff @(posedge clk) begin
		if (srst) begin
			enable_ff <= `QDEL_ENABLE_RST;
		end else begin
			enable_ff <= nxt_enable;
		end
	end

	// secondary clear strobe for the queue-side register
	always_ff @(posedge clk) begin
		if (srst) begin
			sec_clr_ff <= 8'h00;
		end else begin
			sec_clr_ff <= sw_clear;
		end
	end

	// =================================================================
	// submission: fixed priority, lowest channel first
	// a flag cleared by software this cycle is not offered,
	// otherwise a cancelled channel would still reach the controller
	always_comb begin
		low_ch = 3'h0;
		for (int i = `QDEL_NUM_CH - 1; i >= 0; i--) begin
			if (flags_ff[i] && !sw_clear[i]) begin
				low_ch = 3'(i);
			end
		end
	end

	// a channel stays offered until the controller takes it or software clears its flag
	always_ff @(posedge clk) begin
		if (srst) begin
			offer_ff    <= QDEL_IDLE;
			offer_ch_ff <= 3'h0;
		end else begin
			case (offer_ff)
				QDEL_IDLE: begin
					if ((flags_ff & ~sw_clear) != 8'h00) begin
						offer_ff    <= QDEL_OFFER;
						offer_ch_ff <= low_ch;
					end
				end
				QDEL_OFFER: begin
					// a software clear withdraws the offer too
					if (submit_ready || sw_clear[offer_ch_ff]) begin
						offer_ff <= QDEL_IDLE;
					end
				end
				default: begin
					offer_ff <= QDEL_IDLE;
				end
			endcase
		end
	end

	// =================================================================
	// interrupt evaluate, present in every region, pulses only with an enabled pending interrupt, for a shadow region one in the region's mask
	assign live_int        = completion_interrupt_enable & completion_interrupt_pending;
	assign region_int_mask = dma_region_access_enable[reg_region*`QDEL_INT_W +: `QDEL_INT_W];

	always_ff @(posedge clk) begin
		if (srst) begin
			geval_ff <= 1'b0;
			reval_ff <= '0;
		end else begin
			geval_ff <= evaluate_bit_req && reg_global && (live_int != '0);
			for (int r = 0; r < `QDEL_NUM_REGIONS; r++) begin
				// only the region written through is pulsed
				reval_ff[r] <= evaluate_bit_req && !reg_global && reg_region == `QDEL_REGION_W'(r)
					&& ((live_int & region_int_mask) != '0);
			end
		end
	end

	// =================================================================
	// read path, one cycle latency
	// masked shadow channels read zero, as their writes do nothing
	always_comb begin
		nxt_rdata = 32'h0000_0000;
		if (reg_addr == `QDEL_OFS_EVENT_FLAGS) begin
			nxt_rdata = {24'h00_0000, flags_ff & acc_mask};
		end else if (reg_addr == `QDEL_OFS_ENABLE) begin
			nxt_rdata = {24'h00_0000, enable_ff & acc_mask};
		end
		// write-only and unmapped words read zero; evaluate too
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			rdata_ff  <= 32'h0000_0000;
			rvalid_ff <= 1'b0;
		end else begin
			rvalid_ff <= reg_rd;
			if (reg_rd) begin
				rdata_ff <= nxt_rdata;
			end
		end
	end

	// =================================================================
	// outputs
	assign reg_rdata                   = rdata_ff;
	assign reg_rvalid                  = rvalid_ff;
	assign submit_valid                = (offer_ff == QDEL_OFFER);
	assign submit_channel              = offer_ch_ff;
	assign quick_channel_missed_events = missed_ff;
	assign quick_secondary_event_clear = sec_clr_ff;
	assign global_completion_pulse     = geval_ff;
	assign region_completion_pulse     = reval_ff;

endmodule // qdel_event_latch

// ---- qdel_props.sv ----
`timescale 1ns/10ps
// =====================================================================
// port checker for the event latch
module qdel_props (
	input wire logic        clk,
	input wire logic        srst,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic        reg_global,
	input wire logic [1:0]  reg_region,
	input wire logic [7:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic [31:0] reg_rdata,
	input wire logic        reg_rvalid,
	input wire logic [31:0] completion_interrupt_enable,
	input wire logic [31:0] completion_interrupt_pending,
	input wire logic        global_completion_pulse,
	input wire logic [3:0]  region_completion_pulse,
	input wire logic        submit_valid,
	input wire logic [2:0]  submit_channel,
	input wire logic        submit_ready,
	input wire logic [7:0]  quick_secondary_event_clear
);
	// decode helpers; bit one of evaluate is never looked at
	wire any_pend = |(completion_interrupt_enable & completion_interrupt_pending);
	wire evaluate_bit_wr  = reg_wr && reg_addr == 8'h14 && reg_wdata[0];
	wire sec_wr   = reg_wr && reg_addr == 8'h10;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	sequence s_evaluate_bit(g);
		evaluate_bit_wr && reg_global == g;
	endsequence
	property p_evaluate_bit_glb; s_evaluate_bit(1'b1) ##0 any_pend |=> global_completion_pulse; endproperty
	a_evaluate_bit_glb: assert property (p_evaluate_bit_glb) else $error("evaluate pulse missing");
	property p_evaluate_bit_cause; global_completion_pulse |-> $past(evaluate_bit_wr && reg_global); endproperty
	a_evaluate_bit_cause: assert property (p_evaluate_bit_cause) else $error("stray pulse");
	property p_evaluate_bit_reg; |region_completion_pulse |-> $past(evaluate_bit_wr && !reg_global)
		&& region_completion_pulse == 4'h1 << $past(reg_region); endproperty
	a_evaluate_bit_reg: assert property (p_evaluate_bit_reg) else $error("wrong region pulse");
	property p_evaluate_bit_one; s_evaluate_bit(1'b1) ##1 !reg_wr |=> !global_completion_pulse; endproperty
	a_evaluate_bit_one: assert property (p_evaluate_bit_one) else $error("pulse too long");
	property p_rd_lo; reg_rd && reg_addr inside {8'h00, 8'h04}
		|=> reg_rvalid && reg_rdata[31:8] == 24'h0; endproperty
	a_rd_lo: assert property (p_rd_lo) else $error("upper bits set");
	property p_rd_wo; reg_rd && reg_addr inside {8'h08, 8'h0c, 8'h10, 8'h14}
		|=> reg_rdata == 32'h0; endproperty
	a_rd_wo: assert property (p_rd_wo) else $error("write only word read back");
	property p_hold; submit_valid && !submit_ready && !sec_wr
		|=> submit_valid && $stable(submit_channel); endproperty
	a_hold: assert property (p_hold) else $error("offer dropped");
	property p_gap; submit_valid && submit_ready |=> !submit_valid; endproperty
	a_gap: assert property (p_gap) else $error("no gap after accept");
	property p_sec; sec_wr && reg_global |=> quick_secondary_event_clear == $past(reg_wdata[7:0]);
	endproperty
	a_sec: assert property (p_sec) else $error("secondary clear mask");
endmodule // qdel_props
bind qdel_event_latch qdel_props u_props (.*);

// ---- qdel_tc_model.sv ----
`timescale 1ns/10ps
// =====================================================================
// transfer controller stand-in: takes offers promptly or late
module qdel_tc_model (
	input  wire logic       clk,
	input  wire logic       srst,
	input  wire logic       stall,
	input  wire logic       slow,
	input  wire logic       submit_valid,
	input  wire logic [2:0] submit_channel,
	output logic            submit_ready,
	output logic [7:0]      acc_mask,
	output logic [7:0]      acc_cnt
);
	logic [1:0] wait_ff;
	// slow mode lets an offer stand three cycles, to prove it is held
	assign submit_ready = submit_valid && !stall && (!slow || wait_ff == 2'h3);
	always_ff @(posedge clk) begin
		if (srst || !submit_valid || submit_ready) begin
			wait_ff <= 2'h0;
		end else if (wait_ff != 2'h3) begin
			wait_ff <= wait_ff + 2'h1;
		end
	end
	// accepted channels and their count, for the bench
	always_ff @(posedge clk) begin
		if (srst) begin
			acc_mask <= 8'h0;
			acc_cnt <= 8'h0;
		end else if (submit_valid && submit_ready) begin
			acc_mask[submit_channel] <= 1'b1;
			acc_cnt <= acc_cnt + 8'h1;
		end
	end
endmodule // qdel_tc_model

// ---- tb.sv ----
`timescale 1ns/10ps
// =====================================================================
// bench for the quick channel event latch
module tb;
	logic         clk, srst, reg_wr, reg_rd, reg_global, reg_rvalid, stall, slow;
	logic         parameter_ram_wr_valid, link_upd_valid, global_completion_pulse;
	logic         submit_valid, submit_ready;
	logic [1:0]   reg_region;
	logic [2:0]   parameter_ram_wr_word, submit_channel;
	logic [3:0]   region_completion_pulse, rp_seen;
	logic [7:0]   reg_addr, missed_clear, quick_channel_missed_events, n0;
	logic [7:0]   quick_secondary_event_clear, acc_mask, acc_cnt, en, flg, mis;
	logic [8:0]   parameter_ram_wr_entry, link_upd_entry;
	logic [23:0]  quick_channel_trigger_word;
	logic [31:0]  reg_wdata, reg_rdata, quick_region_access_enable, gp_cnt;
	logic [31:0]  completion_interrupt_enable, completion_interrupt_pending;
	logic [31:0]  seed = 32'h48ba;
	logic [71:0]  quick_channel_parameter_ram_mapping;
	logic [127:0] dma_region_access_enable;
	int           bad_count, check_count;

	qdel_event_latch dut (.*);
	qdel_tc_model u_tc (.*);

	// clock and pulse tallies
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (srst) begin
			gp_cnt <= 32'h0;
			rp_seen <= 4'h0;
		end else begin
			gp_cnt <= gp_cnt + 32'(global_completion_pulse);
			rp_seen <= rp_seen | region_completion_pulse;
		end
	end

	// =====================================================================
	// helpers
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// one register access; strobe dropped a cycle before the next
	task automatic xfer(logic w, logic [7:0] a, logic [31:0] d, logic [31:0] x,
		logic g = 1'b1, logic [1:0] r = 2'h0);
		reg_wr <= w;
		reg_rd <= !w;
		reg_addr <= a;
		reg_wdata <= d;
		reg_global <= g;
		reg_region <= r;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		#1;
		chk("rvalid", {31'h0, reg_rvalid}, {31'h0, !w});
		if (!w) chk($sformatf("read %h", a), reg_rdata, x);
		@(posedge clk);
	endtask
	// trigger word write or link update hitting channel ch
	task automatic ev(int ch, logic lnk);
		parameter_ram_wr_valid <= !lnk;
		link_upd_valid <= lnk;
		parameter_ram_wr_entry <= quick_channel_parameter_ram_mapping[ch*9 +: 9];
		link_upd_entry <= quick_channel_parameter_ram_mapping[ch*9 +: 9];
		parameter_ram_wr_word <= quick_channel_trigger_word[ch*3 +: 3];
		@(posedge clk);
		parameter_ram_wr_valid <= 1'b0;
		link_upd_valid <= 1'b0;
		mis |= flg & en & 8'(1 << ch);
		flg |= en & 8'(1 << ch);
		@(posedge clk);
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// =====================================================================
	// tests
	initial begin
		{srst, reg_wr, reg_rd, reg_global, parameter_ram_wr_valid, link_upd_valid} = 6'h20;
		{stall, slow, reg_region, reg_addr, reg_wdata, missed_clear} = '0;
		{parameter_ram_wr_entry, link_upd_entry, parameter_ram_wr_word} = '0;
		{en, flg, mis, bad_count, check_count} = '0;
		{completion_interrupt_enable, completion_interrupt_pending} = '0;
		quick_region_access_enable = 32'hffffffff;
		dma_region_access_enable = {32'h0, 32'h1, 32'h0, 32'h1};
		for (int i = 0; i < 8; i++) begin
			void'(rnd());
			quick_channel_parameter_ram_mapping[i*9 +: 9] = {seed[5:0], 3'(i)};
			quick_channel_trigger_word[i*3 +: 3] = seed[8:6];
		end
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		xfer(1'b0, 8'h00, 0, 0);
		xfer(1'b1, 8'h04, 32'hff, 0);
		xfer(1'b0, 8'h04, 0, 0);
		xfer(1'b0, 8'h40, 0, 0);
		$display("test reset_values done");
		for (int i = 0; i < 6; i++) begin
			xfer(1'b1, 8'h0c, rnd(), 0);
			en |= seed[7:0];
			xfer(1'b1, 8'h08, rnd(), 0);
			en &= ~seed[7:0];
			xfer(1'b0, 8'h04, 0, en);
		end
		xfer(1'b1, 8'h0c, 32'h7f, 0);
		xfer(1'b1, 8'h08, 32'h80, 0);
		en = 8'h7f;
		quick_region_access_enable[15:8] <= 8'h0f;
		xfer(1'b0, 8'h04, 0, en & 8'h0f, 1'b0, 2'h1);
		xfer(1'b1, 8'h08, 32'h30, 0, 1'b0, 2'h1);
		xfer(1'b0, 8'h04, 0, en);
		$display("test enable done");
		stall <= 1'b1;
		for (int i = 0; i < 8; i++) ev(i, i[0]);
		ev(2, 1'b0);
		ev(5, 1'b1);
		xfer(1'b0, 8'h00, 0, flg);
		chk("missed", quick_channel_missed_events, mis);
		missed_clear <= 8'hff;
		@(posedge clk);
		missed_clear <= 8'h00;
		@(posedge clk);
		chk("missed cleared", quick_channel_missed_events, 0);
		xfer(1'b1, 8'h10, 32'h2, 0);
		flg &= 8'hfd;
		xfer(1'b0, 8'h00, 0, flg);
		$display("test events done");
		slow <= 1'b1;
		stall <= 1'b0;
		for (int i = 0; i < 200 && acc_mask !== flg; i++) @(posedge clk);
		chk("accepted", acc_mask, flg);
		xfer(1'b0, 8'h00, 0, 0);
		slow <= 1'b0;
		n0 = acc_cnt;
		ev(3, 1'b0);
		ev(3, 1'b0);
		repeat (20) @(posedge clk);
		chk("accept count", acc_cnt - n0, 2);
		$display("test submit done");
		completion_interrupt_enable <= rnd() | 32'h1;
		completion_interrupt_pending <= 32'h1;
		quick_region_access_enable <= 32'h0;
		xfer(1'b1, 8'h14, 32'h1, 0);
		xfer(1'b1, 8'h14, 32'h0, 0);
		for (int k = 0; k < 4; k++) xfer(1'b1, 8'h14, 32'h1, 0, 1'b0, 2'(k));
		completion_interrupt_enable <= 32'h0;
		xfer(1'b1, 8'h14, 32'h1, 0);
		// let the tally take in a pulse from the last write
		@(posedge clk);
		chk("global pulses", gp_cnt, 1);
		chk("region pulses", rp_seen, 4'h5);
		$display("test evaluate done");
		summarize();
	end

	// hang guard, far beyond the few hundred cycles the tests need
	initial begin
		#50000;
		bad_count++;
		summarize();
	end
endmodule // tb
